// file: pkg/wiper_pkg.sv
package wiper_pkg;

	// Serial word layout and channel count
	localparam int WORD_BITS = 10;
	localparam int CODE_BITS = 8;
	localparam int ADDR_BITS = 2;
	localparam int CHANNELS  = 4;

	// Wiper codes
	localparam logic [7:0] MIDSCALE_CODE = 8'h80;
	localparam logic [7:0] BOTTOM_CODE   = 8'h00;

	// Host serial clock figure and system clock figure
	localparam int HOST_SCLK_MHZ = 10;
	localparam int HOST_SCLK_NS  = 1000 / HOST_SCLK_MHZ;
	localparam int MCLK_NS       = 50;

	// Synchroniser reset levels
	localparam logic SYNC_IDLE_HIGH = 1'b1;

	// Open-drain data level when driving
	localparam logic SDO_DRIVE_LEVEL = 1'b0;

	// APB register map
	localparam int          APB_ADDR_BITS = 12;
	localparam logic [11:0] CODES_OFFSET  = 12'h000;
	localparam logic [11:0] CTRL_OFFSET   = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;

	// Control field positions and reset value
	localparam int         CTRL_SOFT_PRESET_BIT = 0;
	localparam int         CTRL_SOFT_PD_BIT     = 1;
	localparam logic [1:0] CTRL_RESET           = 2'h0;

	// Status field positions
	localparam int STATUS_PD_BIT     = 0;
	localparam int STATUS_PRESET_BIT = 1;
	localparam int STATUS_SELECT_BIT = 2;

	// One serial update word, first shifted bit at the top
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] code;
	} wiper_word_type;

	// Drive state of one resistor channel
	typedef struct packed {
		logic       top_open;
		logic       wiper_to_bottom;
		logic [7:0] tap;
	} channel_state_type;

	typedef struct packed {
		logic soft_power_down;
		logic soft_preset;
	} ctrl_type;

endpackage

// file: rtl/level_sync.sv
`timescale 1ns/10ps

module level_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Level in and out
	input  wire logic level_i,
	output logic      level_o
);

	logic meta_q;
	logic meta_d;
	logic stable_q;
	logic stable_d;

	// First stage feeds only the second
	always_comb begin
		meta_d   = level_i;
		stable_d = meta_q;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q   <= RESET_VAL;
			stable_q <= RESET_VAL;
		end else begin
			meta_q   <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign level_o = stable_q;

endmodule

// file: rtl/wiper_code_loader.sv
`timescale 1ns/10ps

// Contract
// - Word is ten bits: two address bits then eight code bits, MSB first.
// - Code goes to the latch numbered by the two address bits.
// - Channels load one word each, in any order.
// - Preset held low forces every latch to midscale 128.
// - Power-down opens top terminals and ties wipers to bottom terminals.
// - Power-down keeps latch contents; wipers return to stored codes afterwards.
// - Serial input works during power-down; serial output driver is off while the power-down pin is low.
// - Codes loaded during power-down take effect only after its release.
// - Eight-bit code picks one of 256 taps; zero is the bottom end.
// - Higher code moves the wiper monotonically toward the top terminal.
// - While select is low each rising serial clock shifts in one bit.
// - Select rising decodes the address and loads the addressed latch.
// - Bit entered ten shifts earlier appears on the open-drain output.
// - Preset pin held low also clears the serial output latch.

module wiper_code_loader
	import wiper_pkg::*;
(
	// System clock and reset
	input  wire logic                                mclk_i,
	input  wire logic                                rst_i,
	// Serial link from the host
	input  wire logic                                sclk_i,
	input  wire logic                                select_n_i,
	input  wire logic                                serial_in_i,
	output logic                                     serial_out_od_o,
	output logic                                     serial_out_od_oe_o,
	// Control pins
	input  wire logic                                midscale_preset_n_i,
	input  wire logic                                power_down_n_i,
	// Resistor channel drive
	output wiper_pkg::channel_state_type [3:0]       chan_o,
	// APB slave
	input  wire logic                                psel_i,
	input  wire logic                                penable_i,
	input  wire logic                                pwrite_i,
	input  wire logic [wiper_pkg::APB_ADDR_BITS-1:0] paddr_i,
	input  wire logic [31:0]                         pwdata_i,
	output logic [31:0]                              prdata_o,
	output logic                                     pready_o,
	output logic                                     pslverr_o
);

	import wiper_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Link domain: shift register and daisy-chain output

	logic [WORD_BITS-1:0] shift_q;
	logic [WORD_BITS-1:0] shift_d;
	logic                 drive_low_q;
	logic                 drive_low_d;
	logic                 od_level_q;
	logic                 link_clr;
	wiper_word_type       word;

	assign word = wiper_word_type'(shift_q);

	// Preset and power-down pins release the output at once, with no link edge needed
	assign link_clr = rst_i | ~midscale_preset_n_i | ~power_down_n_i;

	always_comb begin
		shift_d     = shift_q;
		drive_low_d = drive_low_q;
		if (!select_n_i) begin
			shift_d     = {shift_q[WORD_BITS-2:0], serial_in_i};
			drive_low_d = ~shift_q[WORD_BITS-1];
		end
	end

	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_q    <= '0;
			od_level_q <= SDO_DRIVE_LEVEL;
		end else begin
			shift_q    <= shift_d;
			od_level_q <= SDO_DRIVE_LEVEL;
		end
	end

	// Cleared latch means driver off, so the pull-up shows a high
	always_ff @(posedge sclk_i or posedge link_clr) begin
		if (link_clr) begin
			drive_low_q <= 1'b0;
		end else begin
			drive_low_q <= drive_low_d;
		end
	end

	assign serial_out_od_o    = od_level_q;
	assign serial_out_od_oe_o = drive_low_q;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic select_n_sync;
	logic preset_n_sync;
	logic power_down_n_sync;

	level_sync #(
		.RESET_VAL (SYNC_IDLE_HIGH)
	) u_sync_select (
		.clk_i   (mclk_i),
		.rst_i   (rst_i),
		.level_i (select_n_i),
		.level_o (select_n_sync)
	);

	level_sync #(
		.RESET_VAL (SYNC_IDLE_HIGH)
	) u_sync_preset (
		.clk_i   (mclk_i),
		.rst_i   (rst_i),
		.level_i (midscale_preset_n_i),
		.level_o (preset_n_sync)
	);

	level_sync #(
		.RESET_VAL (SYNC_IDLE_HIGH)
	) u_sync_power_down (
		.clk_i   (mclk_i),
		.rst_i   (rst_i),
		.level_i (power_down_n_i),
		.level_o (power_down_n_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// System domain: latches and channel drive

	logic                         select_n_prev_q;
	logic                         load_pulse;
	logic                         preset_act;
	logic                         pd_act;
	ctrl_type                     ctrl_q;
	ctrl_type                     ctrl_d;
	logic [CHANNELS-1:0][7:0]     latch_q;
	logic [CHANNELS-1:0][7:0]     latch_d;
	channel_state_type [CHANNELS-1:0] chan_q;
	channel_state_type [CHANNELS-1:0] chan_d;

	// The word is sampled at the third system clock edge after select rises; the shift
	// register ignores link edges while select is high, so the word stands still
	assign load_pulse = select_n_sync & ~select_n_prev_q;
	assign preset_act = ~preset_n_sync | ctrl_q.soft_preset;
	assign pd_act     = ~power_down_n_sync | ctrl_q.soft_power_down;

	always_comb begin
		latch_d = latch_q;
		if (preset_act) begin
			for (int i = 0; i < CHANNELS; i++) begin
				latch_d[i] = MIDSCALE_CODE;
			end
		end else if (load_pulse) begin
			// Latches load in whatever order the host chooses
			latch_d[word.addr] = word.code;
		end
	end

	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			chan_d[i].top_open        = pd_act;
			chan_d[i].wiper_to_bottom = pd_act;
			// Tap number equals code: zero is bottom, rising toward the top
			chan_d[i].tap = pd_act ? BOTTOM_CODE : latch_q[i];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			select_n_prev_q <= SYNC_IDLE_HIGH;
			for (int i = 0; i < CHANNELS; i++) begin
				latch_q[i]                <= MIDSCALE_CODE;
				chan_q[i].top_open        <= 1'b0;
				chan_q[i].wiper_to_bottom <= 1'b0;
				chan_q[i].tap             <= MIDSCALE_CODE;
			end
		end else begin
			select_n_prev_q <= select_n_sync;
			latch_q         <= latch_d;
			chan_q          <= chan_d;
		end
	end

	assign chan_o = chan_q;

	////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state per transfer

	logic        pready_q;
	logic        pready_d;
	logic        pslverr_q;
	logic        pslverr_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        apb_answer;
	logic        apb_take;
	logic        addr_mapped;
	logic [31:0] read_word;

	assign apb_answer  = psel_i & penable_i & ~pready_q;
	assign apb_take    = psel_i & penable_i & pready_q;
	assign addr_mapped = (paddr_i == CODES_OFFSET) | (paddr_i == CTRL_OFFSET) |
		(paddr_i == STATUS_OFFSET);

	always_comb begin
		read_word = 32'h0000_0000;
		case (paddr_i)
			CODES_OFFSET: begin
				read_word = {latch_q[3], latch_q[2], latch_q[1], latch_q[0]};
			end
			CTRL_OFFSET: begin
				read_word[CTRL_SOFT_PRESET_BIT] = ctrl_q.soft_preset;
				read_word[CTRL_SOFT_PD_BIT]     = ctrl_q.soft_power_down;
			end
			STATUS_OFFSET: begin
				read_word[STATUS_PD_BIT]     = pd_act;
				read_word[STATUS_PRESET_BIT] = preset_act;
				read_word[STATUS_SELECT_BIT] = ~select_n_sync;
			end
			default: begin
				read_word = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		ctrl_d    = ctrl_q;
		if (apb_answer) begin
			pready_d  = 1'b1;
			pslverr_d = ~addr_mapped;
			prdata_d  = pwrite_i ? 32'h0000_0000 : read_word;
		end
		// Writes land only at the edge that completes the transfer
		if (apb_take && pwrite_i && (paddr_i == CTRL_OFFSET)) begin
			ctrl_d.soft_preset     = pwdata_i[CTRL_SOFT_PRESET_BIT];
			ctrl_d.soft_power_down = pwdata_i[CTRL_SOFT_PD_BIT];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			ctrl_q    <= ctrl_type'(CTRL_RESET);
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
			ctrl_q    <= ctrl_d;
		end
	end

	assign prdata_o  = prdata_q;
	assign pready_o  = pready_q;
	assign pslverr_o = pslverr_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	AST_SHIFT_IN: assert property (
		@(posedge sclk_i) disable iff (rst_i)
		!select_n_i |=> (shift_q[0] == $past(serial_in_i)) &&
			(shift_q[WORD_BITS-1:1] == $past(shift_q[WORD_BITS-2:0]))
	) else $error("shift register did not take the serial bit");

	AST_SHIFT_HOLD: assert property (
		@(posedge sclk_i) disable iff (rst_i)
		select_n_i |=> $stable(shift_q)
	) else $error("shift register moved with select high");

	AST_DAISY_OUT: assert property (
		@(posedge sclk_i) disable iff (link_clr)
		!select_n_i ##1 !link_clr |-> drive_low_q == !$past(shift_q[WORD_BITS-1])
	) else $error("serial output does not show the tenth earlier bit");

	AST_OUT_OFF_PRESET: assert property (
		@(posedge sclk_i) disable iff (rst_i)
		!midscale_preset_n_i |-> !serial_out_od_oe_o
	) else $error("serial output driven during preset");

	AST_OUT_OFF_PD: assert property (
		@(posedge sclk_i) disable iff (rst_i)
		!power_down_n_i |-> !serial_out_od_oe_o
	) else $error("serial output driven during power-down");

	AST_LOAD_TARGET: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(load_pulse && !preset_act) |=> latch_q[$past(word.addr)] == $past(word.code)
	) else $error("addressed latch did not take the code");

	AST_LOAD_OTHERS: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(load_pulse && !preset_act && word.addr != 2'h0) |=> $stable(latch_q[0])
	) else $error("unaddressed latch changed on load");

	AST_SELECT_TO_LOAD: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		$rose(select_n_sync) |-> load_pulse ##1 !load_pulse
	) else $error("select rise did not give one load pulse");

	AST_PRESET_MID: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		preset_act |=> (latch_q[0] == MIDSCALE_CODE) && (latch_q[3] == MIDSCALE_CODE)
	) else $error("preset did not force midscale");

	AST_PD_DRIVE: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		pd_act |=> chan_q[1].top_open && chan_q[1].wiper_to_bottom &&
			(chan_q[1].tap == BOTTOM_CODE)
	) else $error("power-down did not open top and tie wiper to bottom");

	AST_PD_KEEPS: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(pd_act && !preset_act && !load_pulse) |=> $stable(latch_q)
	) else $error("power-down changed latch contents");

	AST_PD_RELEASE: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(!pd_act && $past(pd_act)) |=> !chan_q[2].top_open &&
			(chan_q[2].tap == $past(latch_q[2]))
	) else $error("stored code not restored after power-down");

	AST_DAISY_HOLD: assert property (
		@(posedge sclk_i) disable iff (link_clr)
		select_n_i |=> $stable(drive_low_q)
	) else $error("serial output moved with select high");

	AST_RUN_TAP: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		!pd_act |=> !chan_q[0].wiper_to_bottom && (chan_q[0].tap == $past(latch_q[0]))
	) else $error("running tap does not follow its latch code");

	AST_APB_WAIT: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o
	) else $error("APB answer not given after one wait state");

endmodule

// file: sim/host_serial_model.sv
`timescale 1ns/10ps

module host_serial_model (
	// Serial link towards the device
	output logic      sclk_o,
	output logic      select_n_o,
	output logic      serial_in_o,
	// Open-drain return line, pull-up resolved
	input  wire logic line_i
);
	localparam int HALF_NS = 40;

	logic [19:0] echo;

	initial begin
		sclk_o      = 1'b0;
		select_n_o  = 1'b1;
		serial_in_o = 1'b0;
	end

	// Two words per frame, so the first one falls out on the return line.
	// Any address is legal on the four-channel part.
	task automatic send(input logic [19:0] bits);
		#13;
		select_n_o = 1'b0;
		for (int i = 19; i >= 0; i--) begin
			serial_in_o = bits[i];
			#HALF_NS sclk_o = 1'b1;
			#HALF_NS sclk_o = 1'b0;
			echo[i] = line_i;
		end
		#(2 * HALF_NS) select_n_o = 1'b1;
		// Released data line must not keep showing a stale bit
		serial_in_o = ~serial_in_o;
		// Clock edges with select high are legal and must not shift
		repeat (2) begin
			#HALF_NS sclk_o = 1'b1;
			#HALF_NS sclk_o = 1'b0;
		end
		#90;
	endtask
endmodule

// file: sim/wiper_code_loader_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module wiper_code_loader_tb_top;
	import wiper_pkg::*;

	localparam logic [9:0] PREFIX = 10'h2B4;

	logic                        mclk, rst, sclk, sel_n, serial_in, od, oe, line;
	logic                        preset_n, pd_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0]                 paddr;
	logic [31:0]                 pwdata, prdata;
	channel_state_type [3:0]     chan;
	int                          error_cnt = 0;
	int                          n_compared = 0;
	int                          cycles = 0;

	assign line = oe ? od : 1'b1;

	wiper_code_loader i_dut (
		.mclk_i(mclk), .rst_i(rst), .sclk_i(sclk), .select_n_i(sel_n),
		.serial_in_i(serial_in), .serial_out_od_o(od), .serial_out_od_oe_o(oe),
		.midscale_preset_n_i(preset_n), .power_down_n_i(pd_n), .chan_o(chan),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr)
	);

	host_serial_model i_host (
		.sclk_o(sclk), .select_n_o(sel_n), .serial_in_o(serial_in), .line_i(line)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Read before this edge's updates land, as the slave sees the bus
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic        er;
		apb(1'b0, a, 32'h0, q, er);
		`CHK(q, e)
		`CHK(er, 1'b0)
	endtask

	task automatic taps_chk(input logic [31:0] e, input logic pd);
		for (int i = 0; i < CHANNELS; i++) begin
			`CHK(chan[i].tap, pd ? BOTTOM_CODE : e[8*i+:8])
			`CHK(chan[i].top_open, pd)
			`CHK(chan[i].wiper_to_bottom, pd)
		end
	endtask

	// Driver is off while the preset or power-down pin holds
	task automatic load(input logic [1:0] ch, input logic [7:0] code);
		i_host.send({PREFIX, ch, code});
		`CHK(i_host.echo[9:0], (pd_n && preset_n) ? PREFIX : 10'h3FF)
		tick(7);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_load;
		taps_chk(32'h80808080, 1'b0);
		rd_chk(CODES_OFFSET, 32'h80808080);
		load(2'd3, 8'hFF);
		load(2'd0, 8'h00);
		load(2'd2, 8'h5A);
		load(2'd1, 8'h01);
		taps_chk(32'hFF5A0100, 1'b0);
		rd_chk(CODES_OFFSET, 32'hFF5A0100);
	endtask

	task automatic t_preset;
		`CHK(line, 1'b0)
		@(posedge mclk) preset_n <= 1'b0;
		tick(5);
		taps_chk(32'h80808080, 1'b0);
		`CHK(line, 1'b1)
		load(2'd0, 8'h33);
		taps_chk(32'h80808080, 1'b0);
		@(posedge mclk) preset_n <= 1'b1;
		tick(5);
		rd_chk(CODES_OFFSET, 32'h80808080);
	endtask

	task automatic t_pd;
		load(2'd3, 8'hC3);
		@(posedge mclk) pd_n <= 1'b0;
		tick(5);
		taps_chk(32'hC3808080, 1'b1);
		rd_chk(STATUS_OFFSET, 32'h1);
		load(2'd1, 8'h7E);
		taps_chk(32'h0, 1'b1);
		rd_chk(CODES_OFFSET, 32'hC3807E80);
		@(posedge mclk) pd_n <= 1'b1;
		tick(5);
		taps_chk(32'hC3807E80, 1'b0);
	endtask

	task automatic t_apb;
		logic [31:0] q;
		logic        e;
		rd_chk(CTRL_OFFSET, 32'h0);
		apb(1'b1, CTRL_OFFSET, 32'h3, q, e);
		rd_chk(CTRL_OFFSET, 32'h3);
		rd_chk(STATUS_OFFSET, 32'h3);
		taps_chk(32'h0, 1'b1);
		apb(1'b1, CTRL_OFFSET, 32'h0, q, e);
		tick(3);
		taps_chk(32'h80808080, 1'b0);
		apb(1'b1, 12'h00C, 32'h0, q, e);
		`CHK(e, 1'b1)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			conclude;
		end
	end

	initial begin
		rst = 1'b1;
		preset_n = 1'b1;
		pd_n = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		tick(2);
		t_load;
		t_preset;
		t_pd;
		t_apb;
		conclude;
	end
endmodule
